// *** shared/cdtfr_regs.svh ***
`ifndef CDTFR_REGS_SVH
`define CDTFR_REGS_SVH
// Register byte offsets.
`define CDTFR_OFF_LOAD 12'h400
`define CDTFR_OFF_VALUE 12'h404
`define CDTFR_OFF_CTRL 12'h408
`define CDTFR_OFF_ICLR 12'h40c
`define CDTFR_OFF_RAW 12'h410
`define CDTFR_OFF_MSK 12'h414
`define CDTFR_OFF_RELOAD 12'h418
`define CDTFR_OFF_TICK_DIVIDER 12'h41c
`define CDTFR_OFF_FREE 12'h420
// Control field positions.
`define CDTFR_CTL_FDIV_HI 23
`define CDTFR_CTL_FDIV_LO 16
`define CDTFR_CTL_FREE_EN 9
`define CDTFR_CTL_DBG 8
`define CDTFR_CTL_EN 7
`define CDTFR_CTL_IE 5
`define CDTFR_CTL_DIV_HI 3
`define CDTFR_CTL_DIV_LO 2
`define CDTFR_CTL_WIDE 1
// Top bit of the pre-divider field.
`define CDTFR_TICK_DIVIDER_HI 9
// Reset values and fixed readback.
`define CDTFR_RST_FDIV 8'h3e
`define CDTFR_RST_TICK_DIVIDER 10'h07d
`define CDTFR_ICLR_READ 32'h544d5241
// Extra prescale selector codes and their terminal counts.
`define CDTFR_DIV_1 2'h0
`define CDTFR_DIV_16 2'h1
`define CDTFR_DIV_256 2'h2
`define CDTFR_DIV16_LAST 8'h0f
`define CDTFR_DIV256_LAST 8'hff
`endif

// *** shared/cdtfr_pkg.sv ***
package cdtfr_pkg;
   // Whole state of the timer block.
   typedef struct packed {
      logic [31:0] load_value;
      logic [31:0] current_count;
      logic [7:0] free_prescale;
      logic free_enable;
      logic stop_in_debug;
      logic timer_enable;
      logic timer_irq_enable;
      logic [1:0] extra_div;
      logic wide_counter_select;
      logic [9:0] tick_divider;
      logic [9:0] pre_cnt;
      logic [7:0] ext_cnt;
      logic [7:0] free_pre_cnt;
      logic [31:0] free_counter_value;
      logic irq_pending;
      logic [31:0] rdata;
   } cdtfr_state_t;
endpackage

// *** core/cdtfr_timer.sv ***
// The APB register port was decided locally.
`include "cdtfr_regs.svh"

module cdtfr_timer #(
   parameter int ADDR_W = 12
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host processor status.
   input wire logic debug_halted,
   // Interrupt.
   output logic timer_irq
);

   // Offsets need twelve address bits.
   if (ADDR_W < 12) begin : g_chk
      $error("ADDR_W must be at least 12");
   end

   // Present and next state.
   cdtfr_pkg::cdtfr_state_t s;
   cdtfr_pkg::cdtfr_state_t next_s;

   // Access phase strobes; the slave answers in the first access cycle.
   logic acc;
   logic wr;
   logic rd;
   logic halt;
   logic tick;
   logic ext_last;
   logic zero;
   logic [31:0] ctrl_word;
   logic mapped;

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign pready = acc;

   // Debug halt freezes both counters when requested.
   assign halt = s.stop_in_debug && debug_halted;

   // Control word as read back; reserved bits are zero.
   always_comb begin
      ctrl_word = 32'h0;
      ctrl_word[`CDTFR_CTL_FDIV_HI:`CDTFR_CTL_FDIV_LO] = s.free_prescale;
      ctrl_word[`CDTFR_CTL_FREE_EN] = s.free_enable;
      ctrl_word[`CDTFR_CTL_DBG] = s.stop_in_debug;
      ctrl_word[`CDTFR_CTL_EN] = s.timer_enable;
      ctrl_word[`CDTFR_CTL_IE] = s.timer_irq_enable;
      ctrl_word[`CDTFR_CTL_DIV_HI:`CDTFR_CTL_DIV_LO] = s.extra_div;
      ctrl_word[`CDTFR_CTL_WIDE] = s.wide_counter_select;
   end

   // Address decode; unmapped addresses answer with an error.
   always_comb begin
      unique case (paddr[11:0])
         `CDTFR_OFF_LOAD, `CDTFR_OFF_VALUE, `CDTFR_OFF_CTRL,
         `CDTFR_OFF_ICLR, `CDTFR_OFF_RAW, `CDTFR_OFF_MSK,
         `CDTFR_OFF_RELOAD, `CDTFR_OFF_TICK_DIVIDER, `CDTFR_OFF_FREE:
            mapped = (ADDR_W == 12) || (paddr >> 12) == '0;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = acc && !mapped;

   // The pre-divider wraps at its value, so the tick comes every value+1.
   assign tick = s.timer_enable && !halt
      && (s.pre_cnt == s.tick_divider);
   // Extra prescale: codes 00 and 11 pass every tick.
   always_comb begin
      unique case (s.extra_div)
         `CDTFR_DIV_16: ext_last = (s.ext_cnt == `CDTFR_DIV16_LAST);
         `CDTFR_DIV_256: ext_last = (s.ext_cnt == `CDTFR_DIV256_LAST);
         default: ext_last = 1'b1;
      endcase
   end
   // Terminal count checks only the active width.
   assign zero = s.wide_counter_select ? (s.current_count == 32'h0)
      : (s.current_count[15:0] == 16'h0);

   // Next state: counters, bus writes and read data.
   always_comb begin
      next_s = s;
      // Pre-divider runs while the timer is enabled and not halted.
      if (s.timer_enable && !halt) begin
         next_s.pre_cnt = tick ? 10'h0 : s.pre_cnt + 10'h1;
      end
      // Countdown, always periodic.
      if (tick) begin
         next_s.ext_cnt = ext_last ? 8'h0 : s.ext_cnt + 8'h1;
         if (ext_last) begin
            if (zero) begin
               // Reload and raise the pending flag.
               if (s.wide_counter_select) begin
                  next_s.current_count = s.load_value;
               end else begin
                  next_s.current_count = {16'h0, s.load_value[15:0]};
               end
               next_s.irq_pending = 1'b1;
            end else if (s.wide_counter_select) begin
               next_s.current_count = s.current_count - 32'h1;
            end else begin
               next_s.current_count[15:0] = s.current_count[15:0] - 16'h1;
            end
         end
      end
      // Free counter with its own prescaler; it only ever wraps.
      // A prescaler count left above a lowered prescale wraps at once.
      if (s.free_enable && !halt) begin
         if (s.free_pre_cnt >= s.free_prescale) begin
            next_s.free_pre_cnt = 8'h0;
            next_s.free_counter_value = s.free_counter_value + 32'h1;
         end else begin
            next_s.free_pre_cnt = s.free_pre_cnt + 8'h1;
         end
      end
      // Register writes; byte strobes are ignored, whole words only.
      if (wr && mapped) begin
         unique case (paddr[11:0])
            `CDTFR_OFF_LOAD: begin
               next_s.load_value = pwdata;
               next_s.current_count = pwdata;
            end
            `CDTFR_OFF_RELOAD: begin
               next_s.load_value = pwdata;
            end
            `CDTFR_OFF_CTRL: begin
               next_s.free_prescale =
                  pwdata[`CDTFR_CTL_FDIV_HI:`CDTFR_CTL_FDIV_LO];
               next_s.free_enable = pwdata[`CDTFR_CTL_FREE_EN];
               next_s.stop_in_debug = pwdata[`CDTFR_CTL_DBG];
               next_s.timer_enable = pwdata[`CDTFR_CTL_EN];
               next_s.timer_irq_enable = pwdata[`CDTFR_CTL_IE];
               next_s.extra_div =
                  pwdata[`CDTFR_CTL_DIV_HI:`CDTFR_CTL_DIV_LO];
               next_s.wide_counter_select = pwdata[`CDTFR_CTL_WIDE];
            end
            `CDTFR_OFF_ICLR: begin
               // A zero crossing in the same cycle wins over the clear.
               if (pwdata[0] && !(tick && ext_last && zero)) begin
                  next_s.irq_pending = 1'b0;
               end
            end
            `CDTFR_OFF_TICK_DIVIDER: begin
               next_s.tick_divider = pwdata[`CDTFR_TICK_DIVIDER_HI:0];
               next_s.pre_cnt = 10'h0;
            end
            default: begin
               // Read-only registers ignore writes.
               next_s.rdata = s.rdata;
            end
         endcase
      end
      // Read data captured during the setup cycle.
      next_s.rdata = 32'h0;
      if (psel && !penable && !pwrite && mapped) begin
         unique case (paddr[11:0])
            `CDTFR_OFF_LOAD: next_s.rdata = s.load_value;
            `CDTFR_OFF_RELOAD: next_s.rdata = s.load_value;
            `CDTFR_OFF_VALUE: next_s.rdata = s.current_count;
            `CDTFR_OFF_CTRL: next_s.rdata = ctrl_word;
            `CDTFR_OFF_ICLR: next_s.rdata = `CDTFR_ICLR_READ;
            `CDTFR_OFF_RAW: next_s.rdata = {31'h0, s.irq_pending};
            `CDTFR_OFF_MSK:
               next_s.rdata = {31'h0, s.irq_pending && s.timer_irq_enable};
            `CDTFR_OFF_TICK_DIVIDER: next_s.rdata = {22'h0, s.tick_divider};
            `CDTFR_OFF_FREE: next_s.rdata = s.free_counter_value;
            default: next_s.rdata = 32'h0;
         endcase
      end
   end

   // State register.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.free_prescale <= `CDTFR_RST_FDIV;
         s.timer_irq_enable <= 1'b1;
         s.tick_divider <= `CDTFR_RST_TICK_DIVIDER;
      end else begin
         s <= next_s;
      end
   end

   // Read data is registered; masked interrupt output.
   assign prdata = rd ? s.rdata : 32'h0;
   assign timer_irq = s.irq_pending && s.timer_irq_enable;

   // Checks: each one guards a rule against the registered state.

   // A load write lands in the count at the same edge.
   chk_load_copy: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      wr && mapped && paddr[11:0] == `CDTFR_OFF_LOAD
      |=> s.current_count == $past(pwdata))
      else $error("load write not copied to count");
   // A reload write leaves the running count alone.
   chk_reload_defer: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      wr && mapped && paddr[11:0] == `CDTFR_OFF_RELOAD && !tick
      |=> s.current_count == $past(s.current_count))
      else $error("reload write changed count");
   // Every terminal count raises the pending flag.
   chk_zero_sets: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && zero
      |=> s.irq_pending)
      else $error("terminal count did not set pending");
   // A stopped timer keeps its count.
   chk_disabled_hold: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !s.timer_enable && !wr
      |=> $stable(s.current_count))
      else $error("disabled timer counted");
   // Debug halt freezes both counters.
   chk_debug_halt: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      halt && !wr
      |=> $stable(s.free_counter_value) && $stable(s.current_count))
      else $error("counter moved in debug halt");
   // The interrupt line is pending gated by enable.
   chk_irq_and: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      timer_irq == (s.irq_pending && s.timer_irq_enable))
      else $error("irq not pending and enable");
   // The clear register reads back its fixed word.
   chk_clear_read: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      rd && mapped && paddr[11:0] == `CDTFR_OFF_ICLR
      |-> prdata == `CDTFR_ICLR_READ)
      else $error("clear register read wrong");
   // A disabled free counter does not move.
   chk_free_off: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !s.free_enable
      |=> $stable(s.free_counter_value))
      else $error("free counter ran while disabled");
   // Narrow counting never disturbs the high half except by reload.
   chk_narrow_hi: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      !s.wide_counter_select && tick && !wr
      |=> s.current_count[31:16] == $past(s.current_count[31:16])
         || s.current_count[31:16] == 16'h0)
      else $error("narrow mode touched high half");
   // The masked status reads what the line showed at setup.
   chk_mask_read: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      rd && mapped && paddr[11:0] == `CDTFR_OFF_MSK
      |-> prdata == {31'h0, $past(timer_irq)})
      else $error("masked status read wrong");
   // The raw status reads the pending flag as it stood at setup.
   chk_raw_read: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      rd && mapped && paddr[11:0] == `CDTFR_OFF_RAW
      |-> prdata == {31'h0, $past(s.irq_pending)})
      else $error("raw status read wrong");
   // A write to the count register is ignored.
   chk_count_ro: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      wr && paddr[11:0] == `CDTFR_OFF_VALUE && !tick
      |=> $stable(s.current_count))
      else $error("read-only count was written");
   // Unmapped accesses answer with an error and no data.
   chk_unmapped_err: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      acc && !mapped
      |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   // A clear without a coincident terminal count drops the flag.
   chk_irq_clear: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      wr && mapped && paddr[11:0] == `CDTFR_OFF_ICLR && pwdata[0]
      && !(tick && ext_last && zero)
      |=> !s.irq_pending)
      else $error("clear did not drop pending");
   // Wide reload takes the whole load value.
   chk_wide_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && zero && !wr && s.wide_counter_select
      |=> s.current_count == $past(s.load_value))
      else $error("wide reload wrong");
   // Narrow reload takes only the low half of the load value.
   chk_narrow_reload: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && zero && !wr && !s.wide_counter_select
      |=> s.current_count == {16'h0, $past(s.load_value[15:0])})
      else $error("narrow reload wrong");
   // A divided tick away from zero takes exactly one off the count.
   chk_count_step: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && !zero && !wr && s.wide_counter_select
      |=> s.current_count == $past(s.current_count) - 32'h1)
      else $error("count did not step by one");
   // Ticks swallowed by the extra prescale leave the count alone.
   chk_ext_hold: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      tick && !ext_last && !wr
      |=> $stable(s.current_count))
      else $error("count moved between divided ticks");
   // The free counter steps by one when its prescaler wraps.
   chk_free_step: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      s.free_enable && !halt && s.free_pre_cnt >= s.free_prescale
      |=> s.free_counter_value == $past(s.free_counter_value) + 32'h1)
      else $error("free counter did not step");
   // No countdown tick is produced in debug halt.
   chk_halt_tick: assert property (
      @(posedge ref_clk) disable iff (!arst_n)
      halt |-> !tick)
      else $error("tick during debug halt");

   // Coverage of the main scenarios.
   // A terminal count with reload.
   cov_reload: cover property (@(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && zero);
   // The pending flag being cleared.
   cov_clear: cover property (@(posedge ref_clk) disable iff (!arst_n)
      s.irq_pending ##1 !s.irq_pending);
   // The free counter moving.
   cov_free: cover property (@(posedge ref_clk) disable iff (!arst_n)
      $changed(s.free_counter_value));
   // A reload in narrow mode.
   cov_narrow: cover property (@(posedge ref_clk) disable iff (!arst_n)
      tick && ext_last && zero && !s.wide_counter_select);
   // The free counter held by debug halt.
   cov_halt: cover property (@(posedge ref_clk) disable iff (!arst_n)
      halt && s.free_enable);
endmodule

// *** tb/cdtfr_timer_test.sv ***
`include "cdtfr_regs.svh"

module cdtfr_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and bus drive.
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic debug_halted = 1'b0;
   // Design outputs.
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic timer_irq;
   // Bench bookkeeping.
   int mismatches = 0;
   int n_tests = 0;
   int cyc = 0;
   int seed = 89968;
   logic [31:0] rd;
   logic err;
   int t0;
   int n;
   int p;
   int d;

   cdtfr_timer #(.ADDR_W(12)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .debug_halted(debug_halted),
      .timer_irq(timer_irq));

   // The clock toggles every half period of 5 ns.
   always #5 ref_clk = ~ref_clk;

   // Cycle counter; a hung run is cut short and counted as a mismatch.
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         $display("BAD t=%0t timeout %h %h", $time, cyc, 60000);
         end_of_test();
      end
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test();
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Compares one 32-bit result with its expected value.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer: setup, access until pready, then release.
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      pstrb <= 4'($random(seed));
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reads a register and compares it.
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // Waits, within a bound, until the interrupt line is high.
   task automatic wait_irq();
      int k;
      k = 0;
      while (timer_irq !== 1'b1 && k < 10000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask

   // Two back-to-back reads of the free counter, three cycles apart.
   task automatic free_diff(input logic [31:0] exp);
      logic [31:0] f0;
      xfer(1'b0, `CDTFR_OFF_FREE, 32'h0);
      f0 = rd;
      xfer(1'b0, `CDTFR_OFF_FREE, 32'h0);
      chk(rd - f0, exp);
   endtask

   // Clocks between two terminal counts of the periodic countdown.
   function automatic int period(int ld, int pd, int dv);
      return (ld + 1) * (pd + 1) * dv;
   endfunction

   // Main sequence.
   initial begin
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rchk(`CDTFR_OFF_CTRL, 32'h003e0020);
      rchk(`CDTFR_OFF_TICK_DIVIDER, 32'h0000007d);
      rchk(`CDTFR_OFF_VALUE, 32'h0);
      rchk(`CDTFR_OFF_RAW, 32'h0);
      rchk(`CDTFR_OFF_FREE, 32'h0);
      rchk(`CDTFR_OFF_ICLR, `CDTFR_ICLR_READ);
      rchk(12'h424, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset_values done");
      xfer(1'b1, `CDTFR_OFF_TICK_DIVIDER, 32'hffffffff);
      rchk(`CDTFR_OFF_TICK_DIVIDER, 32'h000003ff);
      n = $random(seed) & 16'hffff;
      xfer(1'b1, `CDTFR_OFF_LOAD, n);
      rchk(`CDTFR_OFF_VALUE, n);
      xfer(1'b1, `CDTFR_OFF_VALUE, 32'h1234);
      rchk(`CDTFR_OFF_VALUE, n);
      xfer(1'b1, `CDTFR_OFF_RELOAD, 32'h7);
      rchk(`CDTFR_OFF_VALUE, n);
      rchk(`CDTFR_OFF_LOAD, 32'h7);
      $display("test load_paths done");
      for (int c = 0; c < 5; c++) begin
         // A load of four or more keeps each period longer than a clear.
         n = 4 + ($random(seed) & 3);
         p = $random(seed) & 3;
         d = (c == 1) ? 16 : (c == 2) ? 256 : 1;
         xfer(1'b1, `CDTFR_OFF_CTRL, 32'h20);
         xfer(1'b1, `CDTFR_OFF_ICLR, 32'h1);
         xfer(1'b1, `CDTFR_OFF_TICK_DIVIDER, p);
         xfer(1'b1, `CDTFR_OFF_LOAD, (c == 4) ? 32'h10000 | n : n);
         xfer(1'b1, `CDTFR_OFF_CTRL,
              32'ha0 | ((c & 3) << 2) | ((c < 4) ? 32'h2 : 32'h0));
         wait_irq();
         t0 = cyc;
         xfer(1'b1, `CDTFR_OFF_ICLR, 32'h1);
         @(posedge ref_clk);
         wait_irq();
         chk(32'(cyc - t0), period(n, p, d));
      end
      $display("test countdown_period done");
      // A zero load with no division sets pending on every clock.
      xfer(1'b1, `CDTFR_OFF_TICK_DIVIDER, 32'h0);
      xfer(1'b1, `CDTFR_OFF_LOAD, 32'h0);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h80);
      xfer(1'b1, `CDTFR_OFF_ICLR, 32'h1);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h0);
      rchk(`CDTFR_OFF_RAW, 32'h1);
      chk(32'(timer_irq), 32'h0);
      rchk(`CDTFR_OFF_MSK, 32'h0);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h20);
      rchk(`CDTFR_OFF_MSK, 32'h1);
      chk(32'(timer_irq), 32'h1);
      xfer(1'b1, `CDTFR_OFF_ICLR, 32'h1);
      rchk(`CDTFR_OFF_RAW, 32'h0);
      chk(32'(timer_irq), 32'h0);
      $display("test irq_mask done");
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h200);
      free_diff(32'h3);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h00020200);
      free_diff(32'h1);
      debug_halted <= 1'b1;
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h300);
      free_diff(32'h0);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h200);
      free_diff(32'h3);
      xfer(1'b1, `CDTFR_OFF_CTRL, 32'h0);
      free_diff(32'h0);
      $display("test free_counter done");
      // Reset in mid-run brings back the reset values.
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      rchk(`CDTFR_OFF_CTRL, 32'h003e0020);
      rchk(`CDTFR_OFF_FREE, 32'h0);
      $display("test mid_reset done");
      end_of_test();
   end
endmodule
